// ===== bench/bpci_command_interp_checker.sv
// Purpose: port-level assertions of bpci_command_interp
// Assumes: one clock, async active-low reset
// Notes:   attached by the bind after the module
`default_nettype none
module bpci_command_interp_checker (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic [7:0]         rxData,
  input wire logic               rxValid,
  input wire logic               bearValid,
  input wire logic               bearLast,
  input wire logic               bearReady,
  input wire logic [7:0]         rcvrData,
  input wire logic               rcvrValid,
  input wire logic               passthruMode,
  input wire logic [1:0]         toneSel,
  input wire logic [10:0]        toneLoHz,
  input wire logic [10:0]        toneHiHz,
  input wire logic [15:0]        fineTune,
  input wire logic signed [13:0] freqOffsetHz,
  input wire logic               streaming,
  input wire logic               burstActive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a stop lets the current string finish, so ready may outlive streaming
  logic midStr_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) midStr_ff <= 1'b0;
    else if (bearValid && bearReady) midStr_ff <= !bearLast;
  end
  sequence s_mid_byte;
    bearValid && bearReady && !bearLast;
  endsequence
  a_tone_super: assert property (toneSel == 2'h3 |-> toneLoHz == 11'h5fd && toneHiHz == 11'h77d)
    else $error("wrong tone pair");
  a_ft_range: assert property (fineTune inside {[16'h0050:16'h0150]})
    else $error("fine tune out of range");
  a_ft_zero: assert property (fineTune == 16'h0100 |-> freqOffsetHz == 14'sh0000)
    else $error("center offset not zero");
  a_ft_top: assert property (fineTune == 16'h0150 |-> freqOffsetHz == 14'sh1388)
    else $error("top offset wrong");
  a_pt_fwd: assert property (rxValid && passthruMode |=> rcvrValid && rcvrData == $past(rxData))
    else $error("byte not forwarded");
  a_burst_stream: assert property (burstActive |-> streaming)
    else $error("burst without stream");
  a_ready_gate: assert property (!streaming && !midStr_ff |-> !bearReady)
    else $error("bearing taken while stopped");
  // a stop may only land on a string boundary
  a_string_whole: assert property (s_mid_byte |=> ##[0:100] bearReady)
    else $error("string cut short");
endmodule
bind bpci_command_interp bpci_command_interp_checker i_chk (.core_clk, .rst_n, .rxData, .rxValid, .bearValid,
  .bearLast, .bearReady, .rcvrData, .rcvrValid, .passthruMode, .toneSel, .toneLoHz, .toneHiHz, .fineTune,
  .freqOffsetHz, .streaming, .burstActive);
`default_nettype wire

// ===== bench/bpci_host_model.sv
// Purpose: host side: sends command lines, collects transmitted bytes
// Assumes: one byte per cycle of rxValid high, back to back
// Notes:   stall toggles txReady to back-pressure the tx FIFO
`default_nettype none
module bpci_host_model (
  input  wire logic       core_clk,
  input  wire logic       stall,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic [7:0]      rxData,
  output logic            rxValid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gotBytes [$];
  initial begin
    txReady = 1'b1;
    rxData = 8'h00;
    rxValid = 1'b0;
  end
  always @(posedge core_clk) begin
    if (txValid && txReady) gotBytes.push_back(txData);
    #1 txReady = stall ? ~txReady : 1'b1;
  end
  // zero bytes are padding of the right-aligned text
  task automatic send_line(input logic [95:0] s);
    logic [103:0] l;
    l = {s, 8'h0d};
    for (int i = 12; i >= 0; i--) begin
      if (l[8*i+:8] == 8'h00) continue;
      @(posedge core_clk);
      #1 rxValid = 1'b1;
      rxData = l[8*i+:8];
    end
    @(posedge core_clk);
    #1 rxValid = 1'b0;
    rxData = ~rxData;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_bpci_command_interp.sv
// Purpose: self-checking bench of bpci_command_interp
// Assumes: burst timer shortened to 2000 cycles
// Notes:   bearing strings are 4 bytes without line feed
`default_nettype none
module tb_bpci_command_interp;
  timeunit 1ns;
  timeprecision 1ps;
  import bpci_pkg::*;
  logic        core_clk, rst_n, rxValid, bearValid, bearLast, bearReady, txValid, txReady, rcvrValid;
  logic        passthruMode, videoAtten, streaming, burstActive, stall, bearOn;
  logic [7:0]  rxData, bearData, txData, rcvrData, gainSetting;
  logic [1:0]  toneSel;
  logic [10:0] toneLoHz, toneHiHz;
  logic [15:0] fineTune;
  logic signed [13:0] freqOffsetHz;
  int          error_cnt, num_checks, strCnt;
  logic [7:0]  bstr [4] = '{8'h42, 8'h2c, 8'h31, 8'h3b};
  bpci_command_interp #(.BURST_CYCLES(2000)) i_dut (.core_clk, .rst_n, .rxData, .rxValid, .bearData,
    .bearValid, .bearLast, .bearReady, .txData, .txValid, .txReady, .rcvrData, .rcvrValid, .passthruMode,
    .toneSel, .toneLoHz, .toneHiHz, .videoAtten, .gainSetting, .fineTune, .freqOffsetHz, .streaming,
    .burstActive);
  bpci_host_model i_host (.core_clk, .stall, .txData, .txValid, .txReady, .rxData, .rxValid);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  // source only starts a string when bearOn, so a pause lands on a boundary
  initial begin
    bearValid = 1'b0;
    bearLast = 1'b0;
    bearData = 8'h00;
    forever begin
      @(posedge core_clk);
      if (bearOn) for (int i = 0; i < 4; i++) begin
        #1 bearValid = 1'b1;
        bearData = bstr[i];
        bearLast = (i == 3);
        do @(posedge core_clk); while (!bearReady);
        if (i == 3) strCnt++;
      end
      #1 bearValid = 1'b0;
      bearData = ~bearData;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_str(input int n);
    for (int k = 0; k < 3000 && strCnt < n; k++) @(posedge core_clk);
    check(strCnt >= n, 1'b1);
  endtask
  // next command only after the line feed of this answer
  task automatic cmd(input logic [95:0] s, input logic [263:0] r);
    logic [7:0] e [$];
    int k, z;
    for (k = 32; k >= 0; k--) if (r[8*k+:8] != 8'h00) e.push_back(r[8*k+:8]);
    e.push_back(CH_CR);
    e.push_back(CH_LF);
    i_host.gotBytes.delete();
    i_host.send_line(s);
    for (k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      z = i_host.gotBytes.size();
      if (z > 0 && i_host.gotBytes[z-1] === CH_LF) break;
    end
    foreach (e[j]) check(i_host.gotBytes[z-e.size()+j], e[j]);
  endtask
  task automatic t_reset();
    check(fineTune, 16'h0100);
    check(freqOffsetHz, 16'h0000);
    check(videoAtten, 1'b0);
  endtask
  task automatic t_tone();
    cmd("TONE=03", "OK");
    check(toneSel, 2'h3);
    check(toneLoHz, 11'h5fd);
    check(toneHiHz, 11'h77d);
    cmd("TONE=04", CH_BEL);
    check(toneSel, 2'h3);
  endtask
  task automatic t_vatt();
    cmd({KW_VATT, "01"}, "OK");
    check(videoAtten, 1'b1);
    cmd({KW_VATT, "00"}, "OK");
    check(videoAtten, 1'b0);
  endtask
  task automatic t_ft();
    logic [31:0] v [3] = '{"0150", "0151", "0050"};
    logic [15:0] b [3] = '{16'h0150, 16'h0100, 16'h0050};
    logic [15:0] o [3] = '{16'h1388, 16'h0000, 16'hec78};
    for (int i = 0; i < 3; i++) begin
      cmd({KW_FTUNE, v[i]}, "OK");
      check(fineTune, b[i]);
      check(freqOffsetHz, o[i]);
    end
    cmd("STATUS", {ST_FTUNE, "0050", ST_TONE, "03", ST_VATT, "00", ST_GAIN, "00"});
  endtask
  task automatic t_stream();
    int n;
    i_host.send_line("START");
    wait_str(strCnt + 2);
    check(streaming, 1'b1);
    cmd("GAIN=12", "OK");
    check(gainSetting, 8'h12);
    wait_str(strCnt + 2);
    cmd("XYZ", CH_BEL);
    n = strCnt;
    repeat (100) @(posedge core_clk);
    check(16'(strCnt - n), 16'h0);
    check(streaming, 1'b0);
  endtask
  task automatic t_burst();
    int n;
    stall = 1'b1;
    i_host.gotBytes.delete();
    n = strCnt;
    i_host.send_line(KW_BURST);
    wait_str(n + 10);
    repeat (200) @(posedge core_clk);
    check(16'(strCnt - n), 16'ha);
    check(16'(i_host.gotBytes.size()), 16'h28);
    i_host.send_line("START");
    wait_str(strCnt + 2);
    bearOn = 1'b0;
    @(posedge core_clk);
    for (int k = 0; k < 100 && bearValid; k++) @(posedge core_clk);
    i_host.send_line(KW_BURST);
    i_host.send_line(KW_BURST);
    n = strCnt;
    bearOn = 1'b1;
    wait_str(n + 10);
    repeat (200) @(posedge core_clk);
    check(16'(strCnt - n), 16'ha);
    bearOn = 1'b0;
    i_host.send_line(KW_BURST);
    repeat (2100) @(posedge core_clk);
    n = strCnt;
    bearOn = 1'b1;
    wait_str(n + 1);
    repeat (200) @(posedge core_clk);
    check(16'(strCnt - n), 16'h1);
    check(burstActive, 1'b0);
    stall = 1'b0;
  endtask
  task automatic t_pt();
    cmd(KW_PT_EN, "OK");
    check(passthruMode, 1'b1);
    i_host.gotBytes.delete();
    i_host.send_line("TONE=01");
    repeat (20) @(posedge core_clk);
    check(toneSel, 2'h3);
    check(16'(i_host.gotBytes.size()), 16'h0);
    cmd(KW_PT_DIS, "OK");
    check(passthruMode, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    stall = 1'b0;
    bearOn = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_tone();
    t_vatt();
    t_ft();
    t_stream();
    t_burst();
    t_pt();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== design/bpci_cmd_dec.sv
// Purpose: decodes one finished command line into a command and its argument
// Assumes: line is right aligned, last character in the low byte
// Notes:   purely combinational; a bad argument decodes as an unknown command
`default_nettype none
module bpci_cmd_dec (
  input  wire logic [8*bpci_pkg::LINE_CHARS-1:0] lineBuf,
  input  wire logic [3:0]                        lineLen,
  output bpci_pkg::bpci_cmd_t                    cmd,
  output logic [15:0]                            argBcd,
  output logic [13:0]                            argBin
);
  import bpci_pkg::*;

  function automatic logic isDig(input logic [7:0] b);
    isDig = (b >= CH_ZERO) && (b <= CH_NINE);
  endfunction

  wire [7:0] d3 = lineBuf[31:24];
  wire [7:0] d2 = lineBuf[23:16];
  wire [7:0] d1 = lineBuf[15:8];
  wire [7:0] d0 = lineBuf[7:0];
  wire dig2 = isDig(d1) && isDig(d0);
  wire dig4 = dig2 && isDig(d3) && isDig(d2);

  assign argBcd = {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
  assign argBin = 14'(d3[3:0] * 1000) + 14'(d2[3:0] * 100) + 14'(d1[3:0] * 10) + 14'(d0[3:0]);

  wire isStart  = (lineLen == 4'h5) && (lineBuf[39:0] == KW_START);
  wire isStop   = (lineLen == 4'h4) && (lineBuf[31:0] == KW_STOP);
  wire isStatus = (lineLen == 4'h6) && (lineBuf[47:0] == KW_STATUS);
  wire isMrst   = (lineLen == 4'h6) && (lineBuf[47:0] == KW_MRST);
  wire isBurst  = (lineLen == 4'h6) && (lineBuf[47:0] == KW_BURST);
  wire isPtEn   = (lineLen == 4'ha) && (lineBuf[79:0] == KW_PT_EN);
  wire isPtDis  = (lineLen == 4'ha) && (lineBuf[79:0] == KW_PT_DIS);
  wire isGain   = (lineLen == 4'h7) && (lineBuf[55:16] == KW_GAIN) && dig2;
  // values outside the documented set are refused, settings untouched
  wire isVatt   = (lineLen == 4'h7) && (lineBuf[55:16] == KW_VATT) && dig2 && (argBcd[7:0] <= 8'h01);
  wire isTone   = (lineLen == 4'h7) && (lineBuf[55:16] == KW_TONE) && dig2 && (argBcd[7:0] <= 8'h03);
  wire isFtune  = (lineLen == 4'h7) && (lineBuf[55:32] == KW_FTUNE) && dig4;

  always_comb begin
    cmd = CMD_BAD;
    if (lineLen == 4'h0) cmd = CMD_NONE;
    else if (isStart) cmd = CMD_START;
    else if (isStop) cmd = CMD_STOP;
    else if (isStatus) cmd = CMD_STATUS;
    else if (isMrst) cmd = CMD_MRST;
    else if (isBurst) cmd = CMD_BURST;
    else if (isPtEn) cmd = CMD_PT_EN;
    else if (isPtDis) cmd = CMD_PT_DIS;
    else if (isGain) cmd = CMD_GAIN;
    else if (isVatt) cmd = CMD_VATT;
    else if (isTone) cmd = CMD_TONE;
    else if (isFtune) cmd = CMD_FTUNE;
  end
endmodule
`default_nettype wire

// ===== design/bpci_command_interp.sv
// Purpose: remote command interpreter of a bearing processor: settings, acks, bearing stream gating
// Assumes: rx bytes come from a same-clock serial receiver; bearing strings come byte by byte
// Notes:   the bearing stream only starts or stops at string boundaries
`default_nettype none
module bpci_command_interp #(
  parameter int BURST_CYCLES = bpci_pkg::BURST_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  input  wire logic [7:0]  bearData,
  input  wire logic        bearValid,
  input  wire logic        bearLast,
  output logic             bearReady,
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  output logic [7:0]       rcvrData,
  output logic             rcvrValid,
  output logic             passthruMode,
  output logic [1:0]       toneSel,
  output logic [10:0]      toneLoHz,
  output logic [10:0]      toneHiHz,
  output logic             videoAtten,
  output logic [7:0]       gainSetting,
  output logic [15:0]      fineTune,
  output logic signed [13:0] freqOffsetHz,
  output logic             streaming,
  output logic             burstActive
);
  import bpci_pkg::*;

  if (BURST_CYCLES < 1 || BURST_CYCLES > 67108863) begin : g_bad_burst
    $error("burst cycle count must fit the 26-bit timer");
  end

  localparam int LW = 8 * LINE_CHARS;
  localparam int RW = 8 * RSP_BYTES;
  localparam logic [3:0] LEN_OVF = 4'hf;
  localparam logic [$clog2(FIFO_DEPTH+1)-1:0] ROOM_LEVEL = ($clog2(FIFO_DEPTH+1))'(FIFO_DEPTH - 3);

  // line assembly
  logic [LW-1:0]  lineBuf_ff;
  logic [3:0]     lineLen_ff;
  logic           exec_ff;
  bpci_cmd_t      cmd;
  logic [15:0]    argBcd;
  logic [13:0]    argBin;

  // settings
  logic           passthru_ff, nxt_passthru;
  logic [1:0]     tone_ff, nxt_tone;
  logic [10:0]    toneLo_ff, toneHi_ff;
  logic           vatt_ff, nxt_vatt;
  logic [7:0]     gain_ff, nxt_gain;
  logic [15:0]    ftBcd_ff, nxt_ftBcd;
  logic signed [13:0] offHz_ff, nxt_offHz;

  // stream and response control
  logic           streamOn_ff, nxt_streamOn;
  logic           burstOn_ff, nxt_burstOn;
  logic [3:0]     burstLeft_ff, nxt_burstLeft;
  logic [25:0]    burstTmr_ff, nxt_burstTmr;
  logic           timeUp_ff, nxt_timeUp;
  logic           resume_ff, nxt_resume;
  logic           midString_ff, nxt_midString;
  logic           respPend_ff, nxt_respPend;
  bpci_rsp_t      respKind_ff, nxt_respKind;
  logic           respActive_ff, nxt_respActive;
  logic [5:0]     respIdx_ff, nxt_respIdx;
  logic           bearReady_ff;
  logic [7:0]     rcvrData_ff;
  logic           rcvrValid_ff;

  // fifo side
  logic           fifoInReady;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifoLevel;

  wire isEnd   = rxValid && (rxData == CH_CR);
  wire newChar = rxValid && (rxData != CH_CR) && (rxData != CH_LF);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineBuf_ff <= '0;
      lineLen_ff <= 4'h0;
      exec_ff    <= 1'b0;
    end else begin
      if (newChar) lineBuf_ff <= {lineBuf_ff[LW-9:0], rxData};
      if (exec_ff) lineLen_ff <= newChar ? 4'h1 : 4'h0;
      else if (newChar && lineLen_ff != LEN_OVF) lineLen_ff <= lineLen_ff + 4'h1;
      exec_ff <= isEnd && (lineLen_ff != 4'h0);
    end
  end

  bpci_cmd_dec u_dec (
    .lineBuf (lineBuf_ff),
    .lineLen (lineLen_ff),
    .cmd     (cmd),
    .argBcd  (argBcd),
    .argBin  (argBin)
  );

  // in pass-thru only the leave command is interpreted; every rx byte, the leave command included, goes to the receiver
  wire  ptFilter = passthru_ff && (cmd != CMD_PT_DIS);
  wire  doExec   = exec_ff && !ptFilter && (cmd != CMD_NONE);
  wire  ftInRange = (argBin >= 14'(FTUNE_MIN)) && (argBin <= 14'(FTUNE_MAX));
  int   offInt;
  assign offInt = (int'(argBin) - FTUNE_CENTER) * FTUNE_STEP_HZ;

  // response text, left aligned
  logic [RW-1:0] statusVec;
  logic [RW-1:0] respVec;
  logic [5:0]    respLen;
  assign statusVec = {ST_FTUNE, 4'h3, ftBcd_ff[15:12], 4'h3, ftBcd_ff[11:8], 4'h3, ftBcd_ff[7:4],
                      4'h3, ftBcd_ff[3:0], ST_TONE, CH_ZERO, 6'h0c, tone_ff, ST_VATT, CH_ZERO,
                      7'h18, vatt_ff, ST_GAIN, 4'h3, gain_ff[7:4], 4'h3, gain_ff[3:0], CH_CR, CH_LF};
  assign respVec = (respKind_ff == RSP_STATUS) ? statusVec :
                   (respKind_ff == RSP_BEL) ? {CH_BEL, CH_CR, CH_LF, {(RW-24){1'b0}}} :
                   {RSP_OK_TXT, CH_CR, CH_LF, {(RW-32){1'b0}}};
  assign respLen = (respKind_ff == RSP_STATUS) ? 6'(LEN_STATUS) :
                   (respKind_ff == RSP_BEL) ? 6'(LEN_BEL) : 6'(LEN_OK);
  wire [7:0] respByte = respVec[RW-1 - 8*respIdx_ff -: 8];

  wire respEmit  = respActive_ff && fifoInReady;
  wire respDone  = respEmit && (respIdx_ff == respLen - 6'h1);
  wire bearTake  = bearValid && bearReady_ff;
  wire strEnd    = bearTake && bearLast;
  wire respStart = respPend_ff && !respActive_ff && !midString_ff && !bearTake;

  wire [7:0] fifoInData  = respEmit ? respByte : bearData;
  wire       fifoInValid = respEmit || bearTake;

  always_comb begin
    nxt_passthru   = passthru_ff;
    nxt_tone       = tone_ff;
    nxt_vatt       = vatt_ff;
    nxt_gain       = gain_ff;
    nxt_ftBcd      = ftBcd_ff;
    nxt_offHz      = offHz_ff;
    nxt_streamOn   = streamOn_ff;
    nxt_burstOn    = burstOn_ff;
    nxt_burstLeft  = burstLeft_ff;
    nxt_burstTmr   = burstTmr_ff;
    nxt_timeUp     = timeUp_ff;
    nxt_resume     = resume_ff;
    nxt_midString  = midString_ff;
    nxt_respPend   = respPend_ff;
    nxt_respKind   = respKind_ff;
    nxt_respActive = respActive_ff;
    nxt_respIdx    = respIdx_ff;

    if (bearTake) nxt_midString = !bearLast;

    if (burstOn_ff) begin
      if (burstTmr_ff != 26'h0) nxt_burstTmr = burstTmr_ff - 26'h1;
      else nxt_timeUp = 1'b1;
    end

    // a counted or timed-out burst ends only at a string end, and sends nothing after it
    if (strEnd && burstOn_ff) begin
      nxt_burstLeft = burstLeft_ff - 4'h1;
      if (burstLeft_ff == 4'h1 || timeUp_ff) begin
        nxt_streamOn = 1'b0;
        nxt_burstOn  = 1'b0;
      end
    end

    if (respStart) begin
      nxt_respActive = 1'b1;
      nxt_respIdx    = 6'h0;
      nxt_respPend   = 1'b0;
    end else if (respEmit) begin
      nxt_respIdx = respIdx_ff + 6'h1;
    end
    if (respDone) begin
      nxt_respActive = 1'b0;
      if (resume_ff) nxt_streamOn = 1'b1;
      nxt_resume = 1'b0;
    end

    if (doExec) begin
      if (cmd != CMD_START && cmd != CMD_MRST && cmd != CMD_PT_DIS && cmd != CMD_BURST) begin
        nxt_streamOn = 1'b0;
        nxt_burstOn  = 1'b0;
        nxt_resume   = 1'b0;
      end
      nxt_respPend = 1'b1;
      nxt_respKind = RSP_OK;
      case (cmd)
        CMD_START: begin
          nxt_streamOn = 1'b1;
          nxt_burstOn  = 1'b0;
          nxt_respPend = 1'b0;
        end
        CMD_STOP: nxt_respPend = 1'b0;
        CMD_STATUS: nxt_respKind = RSP_STATUS;
        CMD_MRST: begin
          nxt_tone  = TONE_RST;
          nxt_vatt  = VATT_RST;
          nxt_gain  = GAIN_RST_BCD;
          nxt_ftBcd = FTUNE_RST_BCD;
          nxt_offHz = 14'sh0;
        end
        // reload ten strings, each burst accepted
        CMD_BURST: begin
          nxt_streamOn  = 1'b1;
          nxt_burstOn   = 1'b1;
          nxt_burstLeft = 4'(BURST_STRINGS);
          nxt_burstTmr  = 26'(BURST_CYCLES - 1);
          nxt_timeUp    = 1'b0;
          nxt_respPend  = 1'b0;
        end
        CMD_GAIN: begin
          nxt_gain   = argBcd[7:0];
          nxt_resume = streamOn_ff;
        end
        // attenuator from value, valid values only
        CMD_VATT: begin
          nxt_vatt   = argBcd[0];
          nxt_resume = streamOn_ff;
        end
        // tone pair select, acked with OK
        CMD_TONE: begin
          nxt_tone = argBcd[1:0];
        end
        // out of range re-centers, 100 Hz steps
        CMD_FTUNE: begin
          if (ftInRange) begin
            nxt_ftBcd = argBcd;
            nxt_offHz = 14'(offInt);
          end else begin
            nxt_ftBcd = FTUNE_RST_BCD;
            nxt_offHz = 14'sh0;
          end
        end
        CMD_PT_EN: begin
          nxt_passthru = 1'b1;
        end
        CMD_PT_DIS: begin
          nxt_passthru = 1'b0;
        end
        CMD_BAD: begin
          nxt_respKind = RSP_BEL;
        end
        default: nxt_respPend = respPend_ff;
      endcase
    end
  end

  // ready looks one cycle ahead so a stopped stream never takes a stray byte
  wire nxt_bearReady = (nxt_midString || (nxt_streamOn && !nxt_respPend && !nxt_respActive))
                       && (fifoLevel <= ROOM_LEVEL);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      passthru_ff <= 1'b0;
      tone_ff     <= TONE_RST;
      toneLo_ff   <= TONE_LO_HZ[TONE_RST];
      toneHi_ff   <= TONE_HI_HZ[TONE_RST];
      vatt_ff     <= VATT_RST;
      gain_ff     <= GAIN_RST_BCD;
      ftBcd_ff    <= FTUNE_RST_BCD;
      offHz_ff    <= 14'sh0;
    end else begin
      passthru_ff <= nxt_passthru;
      tone_ff     <= nxt_tone;
      toneLo_ff   <= TONE_LO_HZ[nxt_tone];
      toneHi_ff   <= TONE_HI_HZ[nxt_tone];
      vatt_ff     <= nxt_vatt;
      gain_ff     <= nxt_gain;
      ftBcd_ff    <= nxt_ftBcd;
      offHz_ff    <= nxt_offHz;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      streamOn_ff   <= 1'b0;
      burstOn_ff    <= 1'b0;
      burstLeft_ff  <= 4'h0;
      burstTmr_ff   <= 26'h0;
      timeUp_ff     <= 1'b0;
      resume_ff     <= 1'b0;
      midString_ff  <= 1'b0;
      respPend_ff   <= 1'b0;
      respKind_ff   <= RSP_OK;
      respActive_ff <= 1'b0;
      respIdx_ff    <= 6'h0;
      bearReady_ff  <= 1'b0;
    end else begin
      streamOn_ff   <= nxt_streamOn;
      burstOn_ff    <= nxt_burstOn;
      burstLeft_ff  <= nxt_burstLeft;
      burstTmr_ff   <= nxt_burstTmr;
      timeUp_ff     <= nxt_timeUp;
      resume_ff     <= nxt_resume;
      midString_ff  <= nxt_midString;
      respPend_ff   <= nxt_respPend;
      respKind_ff   <= nxt_respKind;
      respActive_ff <= nxt_respActive;
      respIdx_ff    <= nxt_respIdx;
      bearReady_ff  <= nxt_bearReady;
    end
  end

  // pass-thru bytes go straight on to the receiver port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcvrData_ff  <= 8'h00;
      rcvrValid_ff <= 1'b0;
    end else begin
      rcvrValid_ff <= rxValid && passthru_ff;
      if (rxValid && passthru_ff) rcvrData_ff <= rxData;
    end
  end

  bpci_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_txfifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inData   (fifoInData),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .level    (fifoLevel),
    .outData  (txData),
    .outValid (txValid),
    .outReady (txReady)
  );

  assign bearReady    = bearReady_ff;
  assign rcvrData     = rcvrData_ff;
  assign rcvrValid    = rcvrValid_ff;
  assign passthruMode = passthru_ff;
  assign toneSel      = tone_ff;
  assign toneLoHz     = toneLo_ff;
  assign toneHiHz     = toneHi_ff;
  assign videoAtten   = vatt_ff;
  assign gainSetting  = gain_ff;
  assign fineTune     = ftBcd_ff;
  assign freqOffsetHz = offHz_ff;
  assign streaming    = streamOn_ff;
  assign burstActive  = burstOn_ff;
endmodule
`default_nettype wire

// ===== design/bpci_fifo.sv
// Purpose: transmit byte FIFO with a registered output stage
// Assumes: single clock, writer honours inReady
// Notes:   capacity is DEPTH words plus the output register
`default_nettype none
module bpci_fifo #(
  parameter int WIDTH = bpci_pkg::FIFO_WIDTH,
  parameter int DEPTH = bpci_pkg::FIFO_DEPTH
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic [WIDTH-1:0]         inData,
  input  wire logic                     inValid,
  output logic                          inReady,
  output logic [$clog2(DEPTH+1)-1:0]    level,
  output logic [WIDTH-1:0]              outData,
  output logic                          outValid,
  input  wire logic                     outReady
);
  import bpci_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 4");
  end

  logic [WIDTH-1:0]       mem [0:DEPTH-1];
  logic [AW-1:0]          wrPtr_ff;
  logic [AW-1:0]          rdPtr_ff;
  logic [$clog2(DEPTH+1)-1:0] count_ff;
  logic [WIDTH-1:0]       outData_ff;
  logic                   outValid_ff;

  wire doWrite = inValid && inReady;
  wire doLoad  = (count_ff != '0) && (!outValid_ff || outReady);

  assign inReady  = (count_ff != ($clog2(DEPTH+1))'(DEPTH));
  assign level    = count_ff;
  assign outData  = outData_ff;
  assign outValid = outValid_ff;

  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff    <= '0;
      rdPtr_ff    <= '0;
      count_ff    <= '0;
      outData_ff  <= '0;
      outValid_ff <= 1'b0;
    end else begin
      if (doWrite) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (doLoad) rdPtr_ff <= rdPtr_ff + 1'b1;
      count_ff <= count_ff + (doWrite ? 1'b1 : 1'b0) - (doLoad ? 1'b1 : 1'b0);
      if (doLoad) begin
        outData_ff  <= mem[rdPtr_ff];
        outValid_ff <= 1'b1;
      end else if (outReady) begin
        outValid_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/bpci_pkg.sv
// Purpose: shared constants and types of the bearing processor command interpreter
// Assumes: core_clk at 250 MHz, ASCII command lines ended by carriage return
// Notes:   keywords are held as ASCII hex so every comparison is a plain vector match
`default_nettype none
package bpci_pkg;
  localparam int CLK_MHZ       = 250;
  localparam int BURST_TIME_US = 170000;
  localparam int BURST_CYC     = BURST_TIME_US * CLK_MHZ;
  localparam int BURST_STRINGS = 10;
  localparam int FTUNE_STEP_HZ = 100;
  localparam int FTUNE_MIN     = 50;
  localparam int FTUNE_MAX     = 150;
  localparam int FTUNE_CENTER  = 100;
  localparam int LINE_CHARS    = 12;
  localparam int FIFO_DEPTH    = 8;
  localparam int FIFO_WIDTH    = 8;

  localparam logic [15:0] FTUNE_RST_BCD = 16'h0100;
  localparam logic [1:0]  TONE_RST     = 2'h0;
  localparam logic [1:0]  TONE_SUPER   = 2'h3;
  localparam logic        VATT_RST     = 1'b0;
  localparam logic [7:0]  GAIN_RST_BCD = 8'h00;

  localparam logic [7:0] CH_CR   = 8'h0d;
  localparam logic [7:0] CH_LF   = 8'h0a;
  localparam logic [7:0] CH_BEL  = 8'h07;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;

  localparam logic [39:0] KW_START   = 40'h5354415254;
  localparam logic [31:0] KW_STOP    = 32'h53544f50;
  localparam logic [47:0] KW_STATUS  = 48'h535441545553;
  localparam logic [47:0] KW_MRST    = 48'h4d5245534554;
  localparam logic [47:0] KW_BURST   = 48'h535155495254;
  localparam logic [39:0] KW_GAIN    = 40'h4741494e3d;
  localparam logic [39:0] KW_VATT    = 40'h5641544e3d;
  localparam logic [39:0] KW_TONE    = 40'h544f4e453d;
  localparam logic [23:0] KW_FTUNE   = 24'h46543d;
  localparam logic [79:0] KW_PT_EN   = 80'h5136583359395a344237;
  localparam logic [79:0] KW_PT_DIS  = 80'h3742345a395933583651;

  localparam logic [39:0] ST_FTUNE = 40'h532046543d;
  localparam logic [47:0] ST_TONE  = 48'h20544f4e453d;
  localparam logic [47:0] ST_VATT  = 48'h205641544e3d;
  localparam logic [47:0] ST_GAIN  = 48'h204741494e3d;
  localparam logic [15:0] RSP_OK_TXT = 16'h4f4b;
  localparam int RSP_BYTES  = 35;
  localparam int LEN_OK     = 4;
  localparam int LEN_BEL    = 3;
  localparam int LEN_STATUS = 35;

  localparam logic [10:0] TONE_LO_HZ [0:3] = '{11'h089, 11'h20e, 11'h3ce, 11'h5fd};
  localparam logic [10:0] TONE_HI_HZ [0:3] = '{11'h0ac, 11'h291, 11'h4c1, 11'h77d};

  typedef enum {CMD_NONE, CMD_START, CMD_STOP, CMD_STATUS, CMD_MRST, CMD_BURST, CMD_GAIN,
                CMD_VATT, CMD_TONE, CMD_FTUNE, CMD_PT_EN, CMD_PT_DIS, CMD_BAD} bpci_cmd_t;
  typedef enum {RSP_OK, RSP_BEL, RSP_STATUS} bpci_rsp_t;
endpackage
`default_nettype wire
